/* File: hdl/stap_pkg.sv */
/*
 * Package for the scan test access port: instruction codes, chain lengths,
 * controller states and the identification word.
 * Assumes nothing of its surroundings.
 */
package stap_pkg;

	localparam int          IR_W       = 4;
	localparam int          ID_W       = 32;
	localparam int          DAP_W      = 35;
	localparam int          NUM_PADS   = 8;
	localparam int          BSC_W      = 3 * NUM_PADS + 1;
	localparam int          RST_CELL   = BSC_W - 1;
	localparam int          CELL_IN    = 0;
	localparam int          CELL_OUT   = 1;
	localparam int          CELL_OE    = 2;
	localparam int          CELLS_PAD  = 3;

	localparam logic [3:0]  INS_EXTEST = 4'h0;
	localparam logic [3:0]  INS_INTEST = 4'h1;
	localparam logic [3:0]  INS_SAMPLE = 4'h2;
	localparam logic [3:0]  INS_ABORT  = 4'h8;
	localparam logic [3:0]  INS_DEBUG_PORT_ACCESS_CHAIN  = 4'hA;
	localparam logic [3:0]  INS_ACCESS_PORT_CHAIN  = 4'hB;
	localparam logic [3:0]  INS_IDENT  = 4'hE;
	localparam logic [3:0]  INS_BYPASS = 4'hF;

	// ir capture pattern, low bits 01 as usual for a tap
	localparam logic [3:0]  IR_CAPTURE = 4'h1;

	// arbitrary identification value, bit 0 must stay 1
	localparam logic [31:0] ID_WORD    = 32'h0000_1001;

	typedef enum logic [15:0] {
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SEL_DR  = 16'h0004,
		ST_CAP_DR  = 16'h0008,
		ST_SH_DR   = 16'h0010,
		ST_EX1_DR  = 16'h0020,
		ST_PA_DR   = 16'h0040,
		ST_EX2_DR  = 16'h0080,
		ST_UPD_DR  = 16'h0100,
		ST_SEL_IR  = 16'h0200,
		ST_CAP_IR  = 16'h0400,
		ST_SH_IR   = 16'h0800,
		ST_EX1_IR  = 16'h1000,
		ST_PA_IR   = 16'h2000,
		ST_EX2_IR  = 16'h4000,
		ST_UPD_IR  = 16'h8000
	} stap_state_e;

	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h0,
		SEL_IDENT  = 3'h1,
		SEL_BSC    = 3'h2,
		SEL_ABORT  = 3'h3,
		SEL_DEBUG_PORT_ACCESS_CHAIN  = 3'h4,
		SEL_ACCESS_PORT_CHAIN  = 3'h5
	} stap_sel_e;

	// instruction decode, undefined codes fall to bypass
	function automatic stap_sel_e stap_decode(input logic [3:0] code);
		unique case (code)
			INS_EXTEST,
			INS_INTEST,
			INS_SAMPLE: stap_decode = SEL_BSC;
			INS_ABORT:  stap_decode = SEL_ABORT;
			INS_DEBUG_PORT_ACCESS_CHAIN:  stap_decode = SEL_DEBUG_PORT_ACCESS_CHAIN;
			INS_ACCESS_PORT_CHAIN:  stap_decode = SEL_ACCESS_PORT_CHAIN;
			INS_IDENT:  stap_decode = SEL_IDENT;
			default:    stap_decode = SEL_BYPASS;
		endcase
	endfunction : stap_decode

endpackage : stap_pkg

/* File: hdl/stap_sync.sv */
/*
 * Two-stage synchroniser for the tap pins.
 * Assumes asynchronous inputs and the system clock.
 */
`timescale 1ns/10ps
module stap_sync
	import stap_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign o_sync = sync_ff;
endmodule : stap_sync

/* File: hdl/stap_fsm.sv */
/*
 * Sixteen-state tap controller, advanced on a test clock rising edge.
 * Assumes a one-cycle rise strobe and synchronised mode select.
 */
`timescale 1ns/10ps
module stap_fsm
	import stap_pkg::*;
(
	input  wire logic  i_mclk,
	input  wire logic  i_rst,
	input  wire logic  i_trst,
	input  wire logic  i_rise,
	input  wire logic  i_tms,
	output stap_state_e o_state
);
	stap_state_e state_ff;
	stap_state_e nxt_state;
	stap_state_e step;

	always_comb begin
		unique case (state_ff)
			ST_RESET:  step = i_tms ? ST_RESET  : ST_IDLE;
			ST_IDLE:   step = i_tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: step = i_tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: step = i_tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  step = i_tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: step = i_tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR:  step = i_tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: step = i_tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: step = i_tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: step = i_tms ? ST_RESET  : ST_CAP_IR;
			ST_CAP_IR: step = i_tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  step = i_tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: step = i_tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR:  step = i_tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: step = i_tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: step = i_tms ? ST_SEL_DR : ST_IDLE;
			default:   step = ST_RESET;
		endcase
		if (i_trst)
			nxt_state = ST_RESET;
		else if (i_rise)
			nxt_state = step;
		else
			nxt_state = state_ff;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			state_ff <= ST_RESET;
		else
			state_ff <= nxt_state;
	end

	assign o_state = state_ff;
endmodule : stap_fsm

/* File: hdl/stap_top.sv */
/*
 * Scan test access port: instruction register, data chains, boundary
 * cells and pad muxing for the debug pins.
 * Assumes test pins arrive asynchronously and are sampled by i_mclk,
 * which runs much faster than the test clock; debug access port logic
 * sits outside and sees the 35-bit chains through update strobes.
 */
// Notes on behaviour
// - four-bit instruction shift chain with parallel holding register
// - shifted instruction becomes active only at Update-IR
// - code 0000 drives pad output and enable from boundary cells
// - code 0001 feeds core pad inputs from boundary input cells
// - reset pin cell is observe only, never overrides core reset
// - code 0010 selects boundary chain; Capture-DR samples all pad signals
// - Shift-DR shifts captured bits out while taking new bits in
// - Update-DR copies chain into holding cells used by test modes
// - boundary chain stays accessible under external and internal test
// - code 1000 selects abort chain for clearing errors or aborting
// - code 1010 selects debug port access chain
// - code 1011 selects access port chain
// - code 1110 selects identification chain, captured and shifted out
// - identification loaded at reset, test reset and Test-Logic-Reset
// - code 1111 selects one-bit bypass register
// - undefined codes behave as bypass
// - debug pins own test function after any reset, no setup
// - no bus registers; chains reached only serially
// - identification chain 32 bits, bit 0 is 1; bypass captures 0
// - three cells per pad: input, output, enable, from nearest pad
// - boundary capture on test clock rising edge in Capture-DR
// - abort, debug port and access port chains are 35 bits
`timescale 1ns/10ps
module stap_top
	import stap_pkg::*;
(
	input  wire logic                i_mclk,
	input  wire logic                i_rst,
	input  wire logic                i_tck,
	input  wire logic                i_tms,
	input  wire logic                i_tdi,
	input  wire logic                i_trst_n,
	output logic                     o_tdo,
	output logic                     o_tdo_oe,
	input  wire logic                i_ext_rst_n,
	input  wire logic [NUM_PADS-1:0] i_pad_in,
	input  wire logic [NUM_PADS-1:0] i_core_out,
	input  wire logic [NUM_PADS-1:0] i_core_oe,
	output logic      [NUM_PADS-1:0] o_pad_out,
	output logic      [NUM_PADS-1:0] o_pad_oe,
	output logic      [NUM_PADS-1:0] o_core_in,
	output logic                     o_core_rst_n,
	output logic                     o_dbg_pin_sel,
	output logic      [DAP_W-1:0]    o_dap_data,
	output logic                     o_abort_upd,
	output logic                     o_debug_port_access_chain_upd,
	output logic                     o_access_port_chain_upd,
	input  wire logic [DAP_W-1:0]    i_dap_capture
);
	// ----------------------------------------------------------------
	// pin sampling and test clock edges
	// ----------------------------------------------------------------
	logic [3:0] pin_s;
	logic       tck_s;
	logic       tms_s;
	logic       tdi_s;
	logic       trst_s_n;
	logic       tck_d_ff;
	logic       nxt_tck_d;
	logic       rise;
	logic       fall;
	stap_state_e state;

	stap_sync #(
		.W(4)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_async ({i_tck, i_tms, i_tdi, i_trst_n}),
		.o_sync  (pin_s)
	);

	assign tck_s    = pin_s[3];
	assign tms_s    = pin_s[2];
	assign tdi_s    = pin_s[1];
	assign trst_s_n = pin_s[0];

	always_comb begin
		nxt_tck_d = tck_s;
	end

	assign rise = tck_s & ~tck_d_ff;
	assign fall = ~tck_s & tck_d_ff;

	stap_fsm u_fsm (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_trst  (~trst_s_n),
		.i_rise  (rise),
		.i_tms   (tms_s),
		.o_state (state)
	);

	// ----------------------------------------------------------------
	// chains
	// ----------------------------------------------------------------
	logic [IR_W-1:0]  ir_sh_ff,  nxt_ir_sh;
	logic [IR_W-1:0]  ir_ff,     nxt_ir;
	logic [ID_W-1:0]  id_sh_ff,  nxt_id_sh;
	logic             byp_ff,    nxt_byp;
	logic [DAP_W-1:0] dap_sh_ff, nxt_dap_sh;
	logic [DAP_W-1:0] dap_ff,    nxt_dap;
	logic [BSC_W-1:0] bs_sh_ff,  nxt_bs_sh;
	logic [BSC_W-1:0] bs_hold_ff, nxt_bs_hold;
	logic [2:0]       upd_ff,    nxt_upd;
	logic             tdo_ff,    nxt_tdo;
	logic             oe_ff,     nxt_oe;
	logic [BSC_W-1:0] bs_cap;
	stap_sel_e        sel;
	logic             in_reset;

	assign sel      = stap_decode(ir_ff);
	assign in_reset = (state == ST_RESET);

	// capture vector: per pad input, output, enable; reset pin on top
	always_comb begin
		bs_cap = '0;
		for (int p = 0; p < NUM_PADS; p++) begin
			bs_cap[CELLS_PAD*p + CELL_IN]  = i_pad_in[p];
			bs_cap[CELLS_PAD*p + CELL_OUT] = o_pad_out[p];
			bs_cap[CELLS_PAD*p + CELL_OE]  = o_pad_oe[p];
		end
		bs_cap[RST_CELL] = i_ext_rst_n;
	end

	always_comb begin
		nxt_ir_sh   = ir_sh_ff;
		nxt_ir      = ir_ff;
		nxt_id_sh   = id_sh_ff;
		nxt_byp     = byp_ff;
		nxt_dap_sh  = dap_sh_ff;
		nxt_dap     = dap_ff;
		nxt_bs_sh   = bs_sh_ff;
		nxt_bs_hold = bs_hold_ff;
		nxt_upd     = '0;
		if (in_reset) begin
			nxt_ir = INS_IDENT;
		end else if (rise) begin
			unique case (state)
				ST_CAP_IR: nxt_ir_sh = IR_CAPTURE;
				ST_SH_IR:  nxt_ir_sh = {tdi_s, ir_sh_ff[IR_W-1:1]};
				ST_CAP_DR: begin
					unique case (sel)
						SEL_IDENT:  nxt_id_sh = ID_WORD;
						SEL_BSC:    nxt_bs_sh = bs_cap;
						SEL_BYPASS: nxt_byp = 1'b0;
						default:    nxt_dap_sh = i_dap_capture;
					endcase
				end
				ST_SH_DR: begin
					unique case (sel)
						SEL_IDENT:  nxt_id_sh = {tdi_s, id_sh_ff[ID_W-1:1]};
						SEL_BSC:    nxt_bs_sh = {tdi_s, bs_sh_ff[BSC_W-1:1]};
						SEL_BYPASS: nxt_byp = tdi_s;
						default:    nxt_dap_sh = {tdi_s, dap_sh_ff[DAP_W-1:1]};
					endcase
				end
				default: ;
			endcase
		end else if (fall) begin
			// update states act on the falling edge, as is usual
			unique case (state)
				ST_UPD_IR: nxt_ir = ir_sh_ff;
				ST_UPD_DR: begin
					unique case (sel)
						SEL_BSC:   nxt_bs_hold = bs_sh_ff;
						SEL_ABORT: begin
							nxt_dap = dap_sh_ff;
							nxt_upd = 3'h1;
						end
						SEL_DEBUG_PORT_ACCESS_CHAIN: begin
							nxt_dap = dap_sh_ff;
							nxt_upd = 3'h2;
						end
						SEL_ACCESS_PORT_CHAIN: begin
							nxt_dap = dap_sh_ff;
							nxt_upd = 3'h4;
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// test output mux, launched on the falling test clock edge
	always_comb begin
		nxt_tdo = tdo_ff;
		nxt_oe  = oe_ff;
		if (fall) begin
			nxt_oe = (state == ST_SH_IR) || (state == ST_SH_DR);
			if (state == ST_SH_IR)
				nxt_tdo = ir_sh_ff[0];
			else begin
				unique case (sel)
					SEL_IDENT:  nxt_tdo = id_sh_ff[0];
					SEL_BSC:    nxt_tdo = bs_sh_ff[0];
					SEL_BYPASS: nxt_tdo = byp_ff;
					default:    nxt_tdo = dap_sh_ff[0];
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tck_d_ff   <= 1'b0;
			ir_sh_ff   <= '0;
			ir_ff      <= INS_IDENT;
			id_sh_ff   <= '0;
			byp_ff     <= 1'b0;
			dap_sh_ff  <= '0;
			dap_ff     <= '0;
			bs_sh_ff   <= '0;
			bs_hold_ff <= '0;
			upd_ff     <= '0;
			tdo_ff     <= 1'b0;
			oe_ff      <= 1'b0;
		end else begin
			tck_d_ff   <= nxt_tck_d;
			ir_sh_ff   <= nxt_ir_sh;
			ir_ff      <= nxt_ir;
			id_sh_ff   <= nxt_id_sh;
			byp_ff     <= nxt_byp;
			dap_sh_ff  <= nxt_dap_sh;
			dap_ff     <= nxt_dap;
			bs_sh_ff   <= nxt_bs_sh;
			bs_hold_ff <= nxt_bs_hold;
			upd_ff     <= nxt_upd;
			tdo_ff     <= nxt_tdo;
			oe_ff      <= nxt_oe;
		end
	end

	// ----------------------------------------------------------------
	// pad and core muxing
	// ----------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < NUM_PADS; p++) begin
			if (ir_ff == INS_EXTEST) begin
				o_pad_out[p] = bs_hold_ff[CELLS_PAD*p + CELL_OUT];
				o_pad_oe[p]  = bs_hold_ff[CELLS_PAD*p + CELL_OE];
			end else begin
				o_pad_out[p] = i_core_out[p];
				o_pad_oe[p]  = i_core_oe[p];
			end
			if (ir_ff == INS_INTEST)
				o_core_in[p] = bs_hold_ff[CELLS_PAD*p + CELL_IN];
			else
				o_core_in[p] = i_pad_in[p];
		end
	end

	assign o_core_rst_n  = i_ext_rst_n;
	assign o_dbg_pin_sel = 1'b1;
	assign o_tdo         = tdo_ff;
	assign o_tdo_oe      = oe_ff;
	assign o_dap_data    = dap_ff;
	assign o_abort_upd   = upd_ff[0];
	assign o_debug_port_access_chain_upd   = upd_ff[1];
	assign o_access_port_chain_upd   = upd_ff[2];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_ident_at_reset;
		@(posedge i_mclk) disable iff (i_rst)
		(state == ST_RESET) |=> (ir_ff == INS_IDENT);
	endproperty
	a_ident_at_reset: assert property (p_ident_at_reset)
		else $error("ident not loaded in reset state");

	property p_ir_only_on_update;
		@(posedge i_mclk) disable iff (i_rst)
		(state != ST_UPD_IR && state != ST_RESET) |=> $stable(ir_ff);
	endproperty
	a_ir_only_on_update: assert property (p_ir_only_on_update)
		else $error("instruction changed outside update");

	property p_oe_in_shift;
		@(posedge i_mclk) disable iff (i_rst)
		o_tdo_oe |-> ($past(state) == ST_SH_IR || $past(state) == ST_SH_DR
			|| state == ST_SH_IR || state == ST_SH_DR
			|| $past(state) == ST_EX1_IR || $past(state) == ST_EX1_DR
			|| state == ST_EX1_IR || state == ST_EX1_DR);
	endproperty
	a_oe_in_shift: assert property (p_oe_in_shift)
		else $error("test output driven outside shift");

	property p_extest_mux;
		@(posedge i_mclk) disable iff (i_rst)
		(ir_ff == INS_EXTEST) |-> (o_pad_out[0] == bs_hold_ff[CELL_OUT]);
	endproperty
	a_extest_mux: assert property (p_extest_mux)
		else $error("pad not driven from boundary cell");

	property p_intest_mux;
		@(posedge i_mclk) disable iff (i_rst)
		(ir_ff == INS_INTEST) |-> (o_core_in[0] == bs_hold_ff[CELL_IN]);
	endproperty
	a_intest_mux: assert property (p_intest_mux)
		else $error("core input not from boundary cell");

	property p_rst_observe;
		@(posedge i_mclk) disable iff (i_rst)
		o_core_rst_n == i_ext_rst_n;
	endproperty
	a_rst_observe: assert property (p_rst_observe)
		else $error("reset pin overridden");

	property p_bypass_cap;
		@(posedge i_mclk) disable iff (i_rst)
		(rise && state == ST_CAP_DR && sel == SEL_BYPASS) |=> !byp_ff;
	endproperty
	a_bypass_cap: assert property (p_bypass_cap)
		else $error("bypass did not capture zero");

	property p_ident_cap;
		@(posedge i_mclk) disable iff (i_rst)
		(rise && state == ST_CAP_DR && sel == SEL_IDENT) |=> id_sh_ff[0];
	endproperty
	a_ident_cap: assert property (p_ident_cap)
		else $error("ident bit 0 not one");

	property p_undef_bypass;
		@(posedge i_mclk) disable iff (i_rst)
		(ir_ff inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD})
			|-> (sel == SEL_BYPASS);
	endproperty
	a_undef_bypass: assert property (p_undef_bypass)
		else $error("undefined code not bypass");

endmodule : stap_top

/* File: bench/stap_tester.sv */
/*
 * Tester model for the scan port: drives test clock, mode select, data in
 * and test reset, and collects test data out, lsb first.
 * Assumes the system clock for pacing; the test clock stays low between
 * scans and each scan starts and ends in Run-Test/Idle.
 */
`timescale 1ns/10ps
module stap_tester
	import stap_pkg::*;
(
	input  wire logic i_mclk,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	output logic      o_trst_n,
	input  wire logic i_tdo,
	input  wire logic i_tdo_oe,
	input  wire logic i_pin_sel
);
	logic oe_seen;

	initial begin
		o_tck    = 1'b0;
		o_tms    = 1'b1;
		o_tdi    = 1'b1;
		o_trst_n = 1'b1;
		oe_seen  = 1'b1;
	end

	// ------------------------------------------------------------
	// test clock periods, four system clocks high and five low
	// ------------------------------------------------------------
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		@(negedge i_mclk);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (4) @(negedge i_mclk);
		o_tck <= 1'b1;
		repeat (4) @(negedge i_mclk);
		tdo = i_tdo;
		o_tck <= 1'b0;
	endtask : step

	// idle to shift, n bits, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [34:0] din,
	                    output logic [34:0] dout);
		logic b;
		dout = '0;
		wait (i_pin_sel === 1'b1);
		step(1'b1, 1'b1, b);
		if (ir)
			step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
		step(1'b0, 1'b1, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
			if (i_tdo_oe !== 1'b1)
				oe_seen = 1'b0;
		end
		step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask : scan

	// five mode-select highs reach Test-Logic-Reset, then idle
	task automatic tlr();
		logic b;
		repeat (5) step(1'b1, 1'b1, b);
		step(1'b0, 1'b1, b);
	endtask : tlr

	task automatic trst();
		logic b;
		@(negedge i_mclk);
		o_trst_n <= 1'b0;
		repeat (6) @(negedge i_mclk);
		o_trst_n <= 1'b1;
		repeat (4) @(negedge i_mclk);
		step(1'b0, 1'b1, b);
	endtask : trst

endmodule : stap_tester

/* File: bench/stap_top_test.sv */
/*
 * Self-checking bench for the scan port: every instruction code, boundary
 * preload with external and internal test, and the ways back to ident.
 * Assumes stap_tester as the far side and a 100 MHz system clock.
 */
`timescale 1ns/10ps
module stap_top_test
	import stap_pkg::*;
;
	typedef struct {
		logic [3:0]  code;
		int          n;
		logic [34:0] exp;
	} stap_row_s;

	localparam logic [34:0] DIN  = 35'h5_A5A5_A5A5;
	localparam logic [34:0] DCAP = 35'h6_1234_5678;
	localparam logic [7:0]  PIN  = 8'h96;
	localparam logic [7:0]  COUT = 8'h3C;
	localparam logic [7:0]  COE  = 8'hF0;

	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic                i_mclk = 1'b0;
	logic                i_rst  = 1'b1;
	logic                ext_rst_n = 1'b1;
	logic                tck, tms, tdi, trst_n, tdo, tdo_oe, pin_sel;
	logic                core_rst_n;
	logic [NUM_PADS-1:0] pad_out, pad_oe, core_in;
	logic [DAP_W-1:0]    dap_data;
	logic [2:0]          upd;
	logic [34:0]         d;
	int                  n_mismatch = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	int                  n_upd[3] = '{0, 0, 0};
	stap_row_s           rows[14];

	always #5 i_mclk = ~i_mclk;

	stap_tester u_tester (
		.i_mclk   (i_mclk),
		.o_tck    (tck),
		.o_tms    (tms),
		.o_tdi    (tdi),
		.o_trst_n (trst_n),
		.i_tdo    (tdo),
		.i_tdo_oe (tdo_oe),
		.i_pin_sel(pin_sel)
	);

	stap_top u_dut (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_tck        (tck),
		.i_tms        (tms),
		.i_tdi        (tdi),
		.i_trst_n     (trst_n),
		.o_tdo        (tdo),
		.o_tdo_oe     (tdo_oe),
		.i_ext_rst_n  (ext_rst_n),
		.i_pad_in     (PIN),
		.i_core_out   (COUT),
		.i_core_oe    (COE),
		.o_pad_out    (pad_out),
		.o_pad_oe     (pad_oe),
		.o_core_in    (core_in),
		.o_core_rst_n (core_rst_n),
		.o_dbg_pin_sel(pin_sel),
		.o_dap_data   (dap_data),
		.o_abort_upd  (upd[0]),
		.o_debug_port_access_chain_upd  (upd[1]),
		.o_access_port_chain_upd  (upd[2]),
		.i_dap_capture(DCAP)
	);

	// ------------------------------------------------------------
	// checks and verdict
	// ------------------------------------------------------------
	function automatic logic [34:0] bsc_pack(input logic [7:0] pin, pout,
	                                         poe, input logic rst);
		bsc_pack = '0;
		for (int p = 0; p < NUM_PADS; p++)
			bsc_pack[3*p +: 3] = {poe[p], pout[p], pin[p]};
		bsc_pack[RST_CELL] = rst;
	endfunction : bsc_pack

	task automatic chk(input logic [34:0] got, input logic [34:0] exp,
	                   input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got,
			         exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	always @(posedge i_mclk) begin
		foreach (upd[k])
			if (upd[k] === 1'b1)
				n_upd[k]++;
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{'{4'hE, ID_W, 35'(ID_WORD)},
		         '{4'h2, BSC_W, bsc_pack(PIN, COUT, COE, 1'b1)},
		         '{4'h8, DAP_W, DCAP}, '{4'hA, DAP_W, DCAP},
		         '{4'hB, DAP_W, DCAP}, '{4'hF, 8, 35'h4A},
		         '{4'h3, 8, 35'h4A}, '{4'h4, 8, 35'h4A}, '{4'h5, 8, 35'h4A},
		         '{4'h6, 8, 35'h4A}, '{4'h7, 8, 35'h4A}, '{4'h9, 8, 35'h4A},
		         '{4'hC, 8, 35'h4A}, '{4'hD, 8, 35'h4A}};
		repeat (3) @(negedge i_mclk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_mclk);
		chk(pin_sel, 1'b1, "pins owned");
		u_tester.tlr();
		u_tester.scan(1'b0, ID_W, DIN, d);
		chk(d, 35'(ID_WORD), "ident at reset");
		$display("test power-on done");
		for (int r = 0; r < 14; r++) begin
			u_tester.scan(1'b1, IR_W, 35'(rows[r].code), d);
			chk(d, 35'(IR_CAPTURE), "ir capture");
			u_tester.scan(1'b0, rows[r].n, DIN, d);
			chk(d, rows[r].exp, "dr out");
			if (rows[r].code inside {INS_ABORT, INS_DEBUG_PORT_ACCESS_CHAIN, INS_ACCESS_PORT_CHAIN})
				chk(dap_data, DIN, "dap data");
			chk(tdo_oe, 1'b0, "tdo idle");
		end
		foreach (n_upd[k])
			chk(35'(n_upd[k]), 35'h1, "dap pulses");
		$display("test instruction table done");
		u_tester.scan(1'b1, IR_W, 35'(INS_SAMPLE), d);
		u_tester.scan(1'b0, BSC_W, bsc_pack(8'h0F, 8'hA5, 8'h5A, 1'b0), d);
		chk({pad_oe, pad_out}, {COE, COUT}, "preload only");
		u_tester.scan(1'b1, IR_W, 35'(INS_EXTEST), d);
		chk({pad_oe, pad_out}, 35'h5AA5, "extest pads");
		chk(core_in, PIN, "extest core in");
		u_tester.scan(1'b0, BSC_W, bsc_pack(8'hC3, 8'h11, 8'h22, 1'b1), d);
		chk({pad_oe, pad_out}, 35'h2211, "extest reload");
		u_tester.scan(1'b1, IR_W, 35'(INS_INTEST), d);
		chk(core_in, 8'hC3, "intest core in");
		chk({pad_oe, pad_out}, {COE, COUT}, "intest pads");
		ext_rst_n = 1'b0;
		@(negedge i_mclk);
		chk(core_rst_n, 1'b0, "reset pin");
		ext_rst_n = 1'b1;
		$display("test boundary done");
		for (int m = 0; m < 3; m++) begin
			u_tester.scan(1'b1, IR_W, 35'(INS_BYPASS), d);
			case (m)
				0: u_tester.tlr();
				1: u_tester.trst();
				default: begin
					i_rst = 1'b1;
					repeat (3) @(negedge i_mclk);
					i_rst = 1'b0;
					u_tester.tlr();
				end
			endcase
			u_tester.scan(1'b0, ID_W, DIN, d);
			chk(d, 35'(ID_WORD), "ident again");
		end
		chk(u_tester.oe_seen, 1'b1, "tdo enable in shifts");
		$display("test return to ident done");
		give_verdict();
	end

endmodule : stap_top_test
